// *** hw/fes_host.sv ***
// Host-side erase command sequencer driving a parallel flash
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ns
// Notes on behaviour
// - Bypass exit is two writes, then device is back in read mode.
// - Chip erase is six writes; the sixth starts the controller.
// - Block erase is six writes; more blocks repeat the sixth write.
// - Host resumes with the resume command, repeatable any times.
// - Host keeps reading status until the toggle bit stops or the error bit shows on two polls in a row.
module fes_host import fes_pkg::*; #(
    parameter int SEL_CYC = SEL_CYC_DEF
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Software register port
    input  wire logic [3:0]  sw_addr,
    input  wire logic [31:0] sw_wdata,
    input  wire logic        sw_wr,
    input  wire logic        sw_rd,
    output logic      [31:0] sw_rdata,
    // Flash pins
    output fes_pins_t        pins,
    input  wire logic [7:0]  data_lines_in
);
    fes_state_t  state_q, state_d;
    fes_cmd_t    cmd_q, cmd_d;
    fes_pins_t   pins_q, pins_d;
    fes_step_t   cur;
    logic [2:0]  step_q, step_d;
    logic [3:0]  ph_q, ph_d;
    logic [12:0] wcnt_q, wcnt_d;
    logic [15:0] sel_q, sel_d;
    logic [16:0] addr_q, addr_d;
    logic [7:0]  first_q, first_d;
    logic [7:0]  last_q, last_d;
    logic        pidx_q, pidx_d;
    logic        err_seen_q, err_seen_d;
    logic        error_q, error_d;
    logic        late_q, late_d;
    logic [31:0] rdata_q, rdata_d;
    logic [7:0]  data_s;
    logic        go;
    logic        sel_mark;
    fes_cmd_t    new_cmd;

    fes_sync #(.W(8)) fes_sync_inst (
        .clk     (clk),
        .reset_n (reset_n),
        .din     (data_lines_in),
        .dout    (data_s)
    );

    function automatic fes_step_t step_of(fes_cmd_t c, logic [2:0] i,
                                          logic [16:0] ba);
        fes_step_t s;
        s      = '{addr: '0, data: '0, last: 1'b1};
        unique case (c)
            CMD_CHIP, CMD_BLOCK: begin
                s.last = (i == 3'h5);
                unique case (i)
                    3'h0, 3'h3: begin
                        s.addr = {6'h00, UNLOCK_A1};
                        s.data = UNLOCK_D1;
                    end
                    3'h1, 3'h4: begin
                        s.addr = {6'h00, UNLOCK_A2};
                        s.data = UNLOCK_D2;
                    end
                    3'h2: begin
                        s.addr = {6'h00, UNLOCK_A1};
                        s.data = CODE_SETUP;
                    end
                    default: begin
                        if (c == CMD_CHIP) begin
                            s.addr = {6'h00, UNLOCK_A1};
                            s.data = CODE_CHIP;
                        end else begin
                            s.addr = ba;
                            s.data = CODE_BLOCK;
                        end
                    end
                endcase
            end
            CMD_ADD: begin
                s.addr = ba;
                s.data = CODE_BLOCK;
            end
            CMD_SUSP:   s.data = CODE_SUSP;
            CMD_RESUME: s.data = CODE_RESUME;
            CMD_BYPX: begin
                s.last = (i == 3'h1);
                s.data = (i == 3'h0) ? CODE_BYP1 : CODE_BYP2;
            end
            default:    s.data = CODE_RESET;
        endcase
        return s;
    endfunction

    assign cur     = step_of(cmd_q, step_q, addr_q);
    assign new_cmd = fes_cmd_t'(sw_wdata[3:0]);
    assign go      = sw_wr && (sw_addr == OFF_CMD) && (state_q == S_IDLE);

    always_comb begin
        state_d    = state_q;
        cmd_d      = cmd_q;
        step_d     = step_q;
        ph_d       = ph_q;
        wcnt_d     = wcnt_q;
        first_d    = first_q;
        last_d     = last_q;
        pidx_d     = pidx_q;
        err_seen_d = err_seen_q;
        error_d    = error_q;
        late_d     = late_q;
        sel_mark   = 1'b0;
        unique case (state_q)
            S_IDLE: begin
                if (go) begin
                    cmd_d  = new_cmd;
                    step_d = 3'h0;
                    ph_d   = 4'h0;
                    pidx_d = 1'b0;
                    err_seen_d = 1'b0;
                    unique case (new_cmd)
                        CMD_ADD: begin
                            if (sel_q >= 16'(SEL_CYC)) begin
                                late_d = 1'b1;
                            end else begin
                                state_d = S_WR;
                            end
                        end
                        CMD_READ, CMD_POLL: state_d = S_RD;
                        CMD_RESET, CMD_CHIP, CMD_BLOCK, CMD_SUSP,
                        CMD_RESUME, CMD_BYPX: begin
                            state_d = S_WR;
                            if (new_cmd == CMD_BLOCK) begin
                                late_d = 1'b0;
                            end
                            if (new_cmd == CMD_RESET) begin
                                error_d = 1'b0;
                            end
                        end
                        default: state_d = S_IDLE;
                    endcase
                end
            end
            S_WR: begin
                ph_d = ph_q + 4'h1;
                if (ph_q == WR_TOT_CYC - 4'h1) begin
                    ph_d = 4'h0;
                    if (!cur.last) begin
                        step_d = step_q + 3'h1;
                    end else begin
                        unique case (cmd_q)
                            CMD_CHIP, CMD_SUSP: state_d = S_RD;
                            CMD_RESET: begin
                                wcnt_d  = 13'h0000;
                                state_d = S_WAIT;
                            end
                            CMD_BLOCK, CMD_ADD: begin
                                sel_mark = 1'b1;
                                state_d  = S_IDLE;
                            end
                            default: state_d = S_IDLE;
                        endcase
                    end
                end
            end
            S_RD: begin
                ph_d = ph_q + 4'h1;
                if (ph_q == RD_TOT_CYC - 4'h1) begin
                    ph_d   = 4'h0;
                    last_d = data_s;
                    if (cmd_q == CMD_READ) begin
                        state_d = S_IDLE;
                    end else if (!pidx_q) begin
                        first_d = data_s;
                        pidx_d  = 1'b1;
                    end else begin
                        state_d = S_POLL;
                    end
                end
            end
            S_POLL: begin
                pidx_d = 1'b0;
                if (first_q[TOGGLE_POS] == last_q[TOGGLE_POS]) begin
                    state_d = S_IDLE;
                end else if (last_q[ERROR_POS] && err_seen_q) begin
                    error_d = 1'b1;
                    state_d = S_IDLE;
                end else begin
                    err_seen_d = last_q[ERROR_POS];
                    state_d    = S_RD;
                end
            end
            S_WAIT: begin
                wcnt_d = wcnt_q + 13'h0001;
                if (wcnt_q == ABORT_CYC - 13'h0001) begin
                    state_d = S_IDLE;
                end
            end
            default: state_d = S_IDLE;
        endcase
    end

    always_comb begin
        pins_d      = '{addr: addr_q, dout: 8'h00, ce_n: 1'b1, oe_n: 1'b1,
                        we_n: 1'b1, dq_oe_n: 1'b1};
        sel_d       = sel_q;
        addr_d      = addr_q;
        rdata_d     = 32'h0000_0000;
        if (state_q == S_WR) begin
            pins_d.addr    = cur.addr;
            pins_d.dout    = cur.data;
            pins_d.ce_n    = 1'b0;
            pins_d.dq_oe_n = 1'b0;
            pins_d.we_n    = !(ph_q < WE_LOW_CYC);
        end else if (state_q == S_RD) begin
            pins_d.ce_n = 1'b0;
            pins_d.oe_n = (ph_q == RD_TOT_CYC - 4'h1);
        end
        if (sel_mark) begin
            sel_d = 16'h0000;
        end else if (sel_q != SEL_CNT_RST) begin
            sel_d = sel_q + 16'h0001;
        end
        if (sw_wr && sw_addr == OFF_ADDR) begin
            addr_d = sw_wdata[16:0];
        end
        if (sw_rd) begin
            if (sw_addr == OFF_STAT) begin
                rdata_d[ST_BUSY] = (state_q != S_IDLE);
                rdata_d[ST_ERR]  = error_q;
                rdata_d[ST_LATE] = late_q;
                rdata_d[ST_BYTE_LO +: 8] = last_q;
            end else if (sw_addr == OFF_ADDR) begin
                rdata_d[16:0] = addr_q;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q    <= S_IDLE;
            cmd_q      <= CMD_NONE;
            step_q     <= 3'h0;
            ph_q       <= 4'h0;
            wcnt_q     <= 13'h0000;
            first_q    <= 8'h00;
            last_q     <= 8'h00;
            pidx_q     <= 1'b0;
            err_seen_q <= 1'b0;
            error_q    <= 1'b0;
            late_q     <= 1'b0;
            sel_q      <= SEL_CNT_RST;
            addr_q     <= 17'h00000;
            rdata_q    <= 32'h0000_0000;
            pins_q     <= '{addr: '0, dout: 8'h00, ce_n: 1'b1, oe_n: 1'b1,
                            we_n: 1'b1, dq_oe_n: 1'b1};
        end else begin
            state_q    <= state_d;
            cmd_q      <= cmd_d;
            step_q     <= step_d;
            ph_q       <= ph_d;
            wcnt_q     <= wcnt_d;
            first_q    <= first_d;
            last_q     <= last_d;
            pidx_q     <= pidx_d;
            err_seen_q <= err_seen_d;
            error_q    <= error_d;
            late_q     <= late_d;
            sel_q      <= sel_d;
            addr_q     <= addr_d;
            rdata_q    <= rdata_d;
            pins_q     <= pins_d;
        end
    end

    assign pins     = pins_q;
    assign sw_rdata = rdata_q;

    a_strobe_excl: assert property (@(posedge clk) disable iff (!reset_n)
        !(!pins_q.we_n && !pins_q.oe_n))
        else $error("write and read strobes low together");
    a_unlock_first: assert property (@(posedge clk)
        disable iff (!reset_n)
        (!pins_q.we_n && (cmd_q == CMD_CHIP || cmd_q == CMD_BLOCK)
         && step_q == 3'h0) |-> (pins_q.addr[10:0] == UNLOCK_A1
         && pins_q.dout == UNLOCK_D1 && !pins_q.dq_oe_n))
        else $error("first unlock write wrong");
    a_unlock_second: assert property (@(posedge clk)
        disable iff (!reset_n)
        (!pins_q.we_n && (cmd_q == CMD_CHIP || cmd_q == CMD_BLOCK)
         && step_q == 3'h1) |-> (pins_q.addr[10:0] == UNLOCK_A2
         && pins_q.dout == UNLOCK_D2))
        else $error("second unlock write wrong");
    a_chip_sixth: assert property (@(posedge clk) disable iff (!reset_n)
        (!pins_q.we_n && cmd_q == CMD_CHIP && step_q == 3'h5)
        |-> (pins_q.addr[10:0] == UNLOCK_A1 && pins_q.dout == CODE_CHIP))
        else $error("chip erase sixth write wrong");
    a_block_sixth: assert property (@(posedge clk) disable iff (!reset_n)
        (!pins_q.we_n && (cmd_q == CMD_BLOCK || cmd_q == CMD_ADD)
         && cur.last) |-> (pins_q.addr == addr_q
         && pins_q.dout == CODE_BLOCK))
        else $error("block select write wrong");
    a_bypass_exit: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == S_WR && cmd_q == CMD_BYPX && step_q == 3'h1
         && ph_q == WR_TOT_CYC - 4'h1) |=> (state_q == S_IDLE
         && $past(pins_q.dout) == CODE_BYP2))
        else $error("bypass exit not two writes");
    a_poll_after: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == S_WR && cmd_q == CMD_CHIP && cur.last
         && ph_q == WR_TOT_CYC - 4'h1) |=> state_q == S_RD ##[1:12]
        !pins_q.oe_n)
        else $error("no status poll after chip erase");
    a_resume_code: assert property (@(posedge clk)
        disable iff (!reset_n)
        (!pins_q.we_n && cmd_q == CMD_RESUME) |-> pins_q.dout == CODE_RESUME)
        else $error("resume code wrong");
    a_abort_wait: assert property (@(posedge clk) disable iff (!reset_n)
        (state_q == S_WAIT && wcnt_q < ABORT_CYC - 13'h0001)
        |=> state_q == S_WAIT)
        else $error("abort wait cut short");
endmodule

// *** hw/fes_pkg.sv ***
// Package: constants and types of the flash erase sequencer host
package fes_pkg;
    // Software register offsets (byte addresses)
    localparam logic [3:0]  OFF_CMD      = 4'h0;
    localparam logic [3:0]  OFF_ADDR     = 4'h4;
    localparam logic [3:0]  OFF_STAT     = 4'h8;
    // Status word fields
    localparam int          ST_BUSY      = 0;
    localparam int          ST_ERR       = 1;
    localparam int          ST_LATE      = 2;
    localparam int          ST_BYTE_LO   = 8;
    // Status byte bits read back from the device
    localparam int          TOGGLE_POS   = 6;
    localparam int          ERROR_POS    = 5;
    // Command address and data values
    localparam logic [10:0] UNLOCK_A1    = 11'h555;
    localparam logic [10:0] UNLOCK_A2    = 11'h2aa;
    localparam logic [7:0]  UNLOCK_D1    = 8'haa;
    localparam logic [7:0]  UNLOCK_D2    = 8'h55;
    localparam logic [7:0]  CODE_SETUP   = 8'h80;
    localparam logic [7:0]  CODE_CHIP    = 8'h10;
    localparam logic [7:0]  CODE_BLOCK   = 8'h30;
    localparam logic [7:0]  CODE_SUSP    = 8'hb0;
    localparam logic [7:0]  CODE_RESUME  = 8'h30;
    localparam logic [7:0]  CODE_BYP1    = 8'h90;
    localparam logic [7:0]  CODE_BYP2    = 8'h00;
    localparam logic [7:0]  CODE_RESET   = 8'hf0;
    // Timing
    localparam int          CLK_MHZ      = 100;
    localparam int          SEL_US       = 50;
    localparam int          SEL_CYC_DEF  = SEL_US * CLK_MHZ;
    localparam int          ABORT_US     = 10;
    localparam logic [12:0] ABORT_CYC    = 13'(ABORT_US * CLK_MHZ);
    localparam logic [3:0]  WE_LOW_CYC   = 4'h4;
    localparam logic [3:0]  WR_TOT_CYC   = 4'h6;
    localparam logic [3:0]  RD_TOT_CYC   = 4'hc;
    localparam logic [15:0] SEL_CNT_RST  = 16'hffff;

    typedef enum logic [3:0] {
        CMD_NONE   = 4'h0,
        CMD_RESET  = 4'h1,
        CMD_CHIP   = 4'h2,
        CMD_BLOCK  = 4'h3,
        CMD_ADD    = 4'h4,
        CMD_SUSP   = 4'h5,
        CMD_RESUME = 4'h6,
        CMD_BYPX   = 4'h7,
        CMD_READ   = 4'h8,
        CMD_POLL   = 4'h9
    } fes_cmd_t;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_WR   = 5'b00010,
        S_RD   = 5'b00100,
        S_POLL = 5'b01000,
        S_WAIT = 5'b10000
    } fes_state_t;

    typedef struct packed {
        logic [16:0] addr;
        logic [7:0]  dout;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        dq_oe_n;
    } fes_pins_t;

    typedef struct packed {
        logic [16:0] addr;
        logic [7:0]  data;
        logic        last;
    } fes_step_t;
endpackage

// *** hw/fes_sync.sv ***
// Three-stage synchroniser with agreement filter
`timescale 1ns/1ns
module fes_sync import fes_pkg::*; #(
    parameter int W = 8
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] out_q;
    logic [W-1:0] out_d;

    always_comb begin
        out_d = out_q;
        for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                out_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            out_q <= '0;
        end else begin
            s1_q  <= din;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            out_q <= out_d;
        end
    end

    assign dout = out_q;
endmodule

// *** tb/fes_flash_model.sv ***
// Behavioural parallel flash with erase sequencing and status reads
`timescale 1ns/1ns
module fes_flash_model import fes_pkg::*; #(
    parameter int         SEL_NS   = 1000,
    parameter int         ERASE_NS = 3000,
    parameter logic [7:0] PROT     = 8'h80
) (
    // Bus from host, and fail_en from the testbench
    input  wire fes_pins_t  pins,
    input  wire logic       fail_en,
    // Data back to host
    output logic      [7:0] data_lines
);
    int         mode    = 0;
    int         step    = 0;
    int         left    = 0;
    int         susp    = 0;
    int         byp_cnt = 0;
    logic [7:0] sel     = 8'h00;
    logic [7:0] erased  = 8'h00;
    logic       chip    = 1'b0;
    logic       tog     = 1'b0;
    logic       alt     = 1'b0;
    logic [7:0] last    = 8'h00;
    logic [2:0] blk;
    logic [7:0] stat;

    assign blk = pins.addr[16:14];

    function automatic logic seq_ok(int s, logic [10:0] a, logic [7:0] d);
        if (s % 3 == 0)
            return a == 11'h555 && d == 8'haa;
        if (s % 3 == 1)
            return a == 11'h2aa && d == 8'h55;
        return a == 11'h555 && d == 8'h80;
    endfunction

    always @(posedge pins.we_n) begin
        logic [10:0] a;
        logic [7:0]  d;
        int          nxt;
        a = pins.addr[10:0];
        d = pins.dout;
        if (!pins.ce_n && !(mode == 2 && chip)) begin
            if (d == 8'hf0) begin
                mode = (mode == 3) ? 3 : 0;
                step = 0;
            end else if (mode == 0) begin
                nxt = 0;
                if (step < 5 && seq_ok(step, a, d)) nxt = step + 1;
                if (step == 0 && d == 8'h90) nxt = 6;
                if (step == 6 && d == 8'h00) byp_cnt++;
                if (step == 5 && d == 8'h10 && a == 11'h555) begin
                    chip = 1'b1;
                    sel = 8'hff;
                    mode = 2;
                    left = ERASE_NS;
                end
                if (step == 5 && d == 8'h30) begin
                    chip = 1'b0;
                    sel = 8'h01 << blk;
                    mode = 1;
                    left = SEL_NS;
                end
                step = nxt;
            end else if (mode == 1 && d == 8'h30) begin
                sel[blk] = 1'b1;
                left = SEL_NS;
            end else if (mode == 1 && d == 8'hb0) begin
                mode = 3;
                left = ERASE_NS;
            end else if (mode == 2 && d == 8'hb0) begin
                susp = 500;
            end else if (mode == 3 && d == 8'h30) begin
                mode = 2;
            end
        end
    end

    always #10 begin
        if (mode == 2 && susp > 0) begin
            susp -= 10;
            if (susp <= 0) mode = 3;
        end else if (mode == 1 || mode == 2) begin
            left -= 10;
            if (left <= 0 && mode == 1) begin
                mode = 2;
                left = ERASE_NS;
            end else if (left <= 0) begin
                if (!fail_en) erased |= sel & ~PROT;
                mode = fail_en ? 4 : 0;
            end
        end
    end

    always @(negedge pins.oe_n) begin
        if (!pins.ce_n && mode != 0) begin
            if (mode != 3) tog = ~tog;
            if (sel[blk]) alt = ~alt;
        end
    end

    always @(data_lines) begin
        if (!pins.ce_n && !pins.oe_n) last = data_lines;
    end

    always @* begin
        stat = {mode == 3, tog, mode == 4, 1'b0, mode > 1, alt, 2'b00};
        if (pins.ce_n || pins.oe_n)
            data_lines = ~last;
        else if (mode == 0 || (mode == 3 && !sel[blk]))
            data_lines = erased[blk] ? 8'hff : pins.addr[7:0] ^ 8'h5a;
        else
            data_lines = stat;
    end
endmodule

// *** tb/fes_host_tb_top.sv ***
// Testbench for the flash erase sequencer host
`timescale 1ns/1ns
module fes_host_tb_top import fes_pkg::*;;
    typedef struct {
        string       name;
        logic [31:0] exp;
        logic [31:0] mask;
    } fes_note_t;
    logic        clk      = 1'b0;
    logic        reset_n  = 1'b0;
    logic [3:0]  sw_addr  = 4'h0;
    logic [31:0] sw_wdata = 32'h0;
    logic        sw_wr    = 1'b0;
    logic        sw_rd    = 1'b0;
    logic        fail_en  = 1'b0;
    logic        rd_d     = 1'b0;
    logic [31:0] sw_rdata;
    logic [31:0] last_rd;
    logic [7:0]  data_lines;
    logic [16:0] ra;
    fes_pins_t   pins;
    int          bad_count = 0;
    int          cmp_count = 0;
    fes_note_t   notes[$];

    always #5 clk = ~clk;

    fes_host #(.SEL_CYC(50)) fes_host_inst (
        .clk(clk), .reset_n(reset_n), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
        .sw_rdata(sw_rdata), .pins(pins), .data_lines_in(data_lines));

    fes_flash_model fes_flash_model_inst (
        .pins(pins), .fail_en(fail_en), .data_lines(data_lines));

    task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic conclude();
        if (bad_count == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic wr(logic [3:0] a, logic [31:0] d);
        @(posedge clk);
        sw_addr <= a;
        sw_wdata <= d;
        sw_wr <= 1'b1;
        @(posedge clk);
        sw_wr <= 1'b0;
    endtask

    task automatic rd(logic [3:0] a, string n, logic [31:0] e,
                      logic [31:0] m);
        notes.push_back('{n, e, m});
        @(posedge clk);
        sw_addr <= a;
        sw_rd <= 1'b1;
        @(posedge clk);
        sw_rd <= 1'b0;
        @(negedge clk);
        #1;
    endtask

    task automatic wait_idle();
        for (int i = 0; i < 600; i++) begin
            rd(OFF_STAT, "poll", 32'h0, 32'h0);
            if (last_rd[ST_BUSY] === 1'b0)
                return;
        end
        bad_count++;
        conclude();
    endtask

    task automatic cmd(logic [3:0] c);
        wr(OFF_CMD, {28'h0, c});
        wait_idle();
    endtask

    // Results are taken in the cycle after each read strobe
    always @(posedge clk) rd_d <= sw_rd;
    always @(negedge clk) begin
        fes_note_t n;
        if (rd_d && notes.size() > 0) begin
            n = notes.pop_front();
            last_rd = sw_rdata;
            if (n.mask != 32'h0)
                check(n.name, sw_rdata & n.mask, n.exp);
        end
    end

    initial begin
        void'($urandom(32'h74f0));
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        rd(OFF_STAT, "stat_rst", 32'h0, 32'hffffffff);
        rd(4'hc, "unmapped", 32'h0, 32'hffffffff);
        cmd(4'h7);
        check("bypass", 32'(fes_flash_model_inst.byp_cnt), 32'h1);
        for (int i = 0; i < 3; i++) begin
            ra = {3'h4 + 3'($urandom_range(2)), 14'($urandom)};
            wr(OFF_ADDR, {15'h0, ra});
            cmd(4'h8);
            rd(OFF_STAT, "rd_byte", {16'h0, ra[7:0] ^ 8'h5a, 8'h0},
               32'hff00);
        end
        wr(OFF_ADDR, 32'h0c000);
        cmd(4'h3);
        cmd(4'h5);
        check("susp_sel", 32'(fes_flash_model_inst.mode), 32'h3);
        cmd(4'h8);
        rd(OFF_STAT, "susp_stat", 32'h8800, 32'hb800);
        cmd(4'h6);
        cmd(4'h9);
        wr(OFF_ADDR, 32'h04000);
        cmd(4'h3);
        wr(OFF_ADDR, 32'h08000);
        cmd(4'h4);
        check("sel", {24'h0, fes_flash_model_inst.sel}, 32'h6);
        for (int i = 0; i < 200; i++) begin
            if (fes_flash_model_inst.mode == 2)
                break;
            @(posedge clk);
        end
        if (fes_flash_model_inst.mode != 2) begin
            bad_count++;
            conclude();
        end
        cmd(4'h5);
        check("susp_run", 32'(fes_flash_model_inst.mode), 32'h3);
        cmd(4'h6);
        cmd(4'h9);
        rd(OFF_STAT, "blk_ok", 32'h0, 32'h3);
        check("erased", {24'h0, fes_flash_model_inst.erased}, 32'he);
        cmd(4'h4);
        rd(OFF_STAT, "late", 32'h4, 32'h4);
        fail_en <= 1'b1;
        cmd(4'h2);
        rd(OFF_STAT, "chip_fail", 32'h2, 32'h3);
        fail_en <= 1'b0;
        cmd(4'h1);
        rd(OFF_STAT, "err_clr", 32'h0, 32'h3);
        wr(OFF_CMD, 32'h2);
        wr(OFF_CMD, 32'h7);
        wait_idle();
        check("busy_cmd", 32'(fes_flash_model_inst.byp_cnt), 32'h1);
        rd(OFF_STAT, "chip_ok", 32'h0, 32'h3);
        wr(OFF_ADDR, 32'h1c011);
        cmd(4'h8);
        rd(OFF_STAT, "prot_blk", 32'h4b00, 32'hff00);
        wr(OFF_ADDR, 32'h10000);
        cmd(4'h8);
        rd(OFF_STAT, "erased_blk", 32'hff00, 32'hff00);
        conclude();
    end
endmodule
